// [hdl/sbrd_pkg.sv]
// Package of constants and types for the system bus read interface
package sbrd_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned RB_DEPTH = 4;
    localparam int unsigned RB_PTR_W = 2;
    localparam int unsigned CNT_W = 3;
    localparam int unsigned OB_DEPTH = 2;

    // ------------------------------------------------------------
    // Port width encodings (region width)
    // ------------------------------------------------------------
    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [1:0] PORT_16 = 2'h1;
    localparam logic [1:0] PORT_8 = 2'h2;

    // ------------------------------------------------------------
    // Request size encodings
    // ------------------------------------------------------------
    localparam logic [2:0] SIZE_BYTE = 3'h0;
    localparam logic [2:0] SIZE_HALF = 3'h1;
    localparam logic [2:0] SIZE_TRI = 3'h2;
    localparam logic [2:0] SIZE_WORD = 3'h3;
    localparam logic [2:0] SIZE_QUAD = 3'h4;

    // ------------------------------------------------------------
    // Constant values
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] QUAD_WORDS = 3'h4;
    localparam logic [CNT_W-1:0] ONE_WORD = 3'h1;
    localparam logic [1:0] LANE_ZERO = 2'h0;
    localparam logic [1:0] LANE_ONE = 2'h1;

    // ------------------------------------------------------------
    // Bus sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SBRD_IDLE = 4'h1,
        SBRD_ADDR = 4'h2,
        SBRD_DATA = 4'h4,
        SBRD_DONE = 4'h8
    } sbrd_state_e;

endpackage

// [hdl/sbrd_read_if.sv]
// Read side of the processor bus interface unit
`timescale 1ns/10ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module sbrd_read_if (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic cache_miss_i,
    input wire logic [31:0] miss_addr_i,
    input wire logic [2:0] miss_size_i,
    input wire logic miss_cacheable_i,
    input wire logic miss_dcache_i,
    input wire logic [1:0] port_width_i,
    input wire logic bus_busy_i,
    input wire logic higher_prio_i,
    input wire logic read_capture_enable_n_i,
    input wire logic read_acknowledge_n_i,
    input wire logic dma_burst_i,
    input wire logic dma_transfer_done_i,
    input wire logic [31:0] system_data_bus_i,
    input wire logic core_ready_i,
    output logic internal_read_request_o,
    output logic stall_o,
    output logic bus_read_strobe_o,
    output logic [31:0] system_address_bus_o,
    output logic address_latch_enable_o,
    output logic burst_frame_marker_o,
    output logic mem_read_enable_n_o,
    output logic core_valid_o,
    output logic [31:0] core_data_o,
    output logic core_refill_o,
    output logic core_fixup_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sbrd_pkg::sbrd_state_e state_reg;
    logic [31:0] rb_mem [sbrd_pkg::RB_DEPTH];
    logic [sbrd_pkg::RB_PTR_W-1:0] wr_ptr_reg;
    logic [sbrd_pkg::RB_PTR_W-1:0] rd_ptr_reg;
    logic [sbrd_pkg::CNT_W-1:0] fill_cnt_reg;
    logic [sbrd_pkg::CNT_W-1:0] words_reg;
    logic [sbrd_pkg::CNT_W-1:0] words_next;
    logic [sbrd_pkg::CNT_W-1:0] unload_cnt_reg;
    logic [sbrd_pkg::CNT_W-1:0] unload_goal_reg;
    logic [1:0] lane_reg;
    logic [1:0] lanes_reg;
    logic [1:0] lanes_next;
    logic [31:0] gather_reg;
    logic [2:0] size_reg;
    logic [1:0] pw_reg;
    logic dcache_reg;
    logic cacheable_reg;
    logic dma_reg;
    logic cap_pend_reg;
    logic ack_reg;
    logic word_done;
    logic last_word;
    logic implicit_ack;
    logic explicit_ack;
    logic rb_empty;
    logic ob_valid_reg [sbrd_pkg::OB_DEPTH];
    logic [31:0] ob_data_reg [sbrd_pkg::OB_DEPTH];
    logic ob_in_ready;
    logic rb_pop;
    logic unloading;
    logic dma_end;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Number of 32-bit words a request needs
    function automatic logic [sbrd_pkg::CNT_W-1:0] f_words(input logic [2:0] sz);
        f_words = (sz == sbrd_pkg::SIZE_QUAD) ? sbrd_pkg::QUAD_WORDS : sbrd_pkg::ONE_WORD;
    endfunction

    // Last lane index of a word for the given port and size
    function automatic logic [1:0] f_lanes(input logic [1:0] pw, input logic [2:0] sz);
        logic [1:0] r;
        r = sbrd_pkg::LANE_ZERO;
        if (pw == sbrd_pkg::PORT_8) begin
            unique case (sz)
                sbrd_pkg::SIZE_BYTE: r = 2'h0;
                sbrd_pkg::SIZE_HALF: r = 2'h1;
                sbrd_pkg::SIZE_TRI: r = 2'h2;
                default: r = 2'h3;
            endcase
        end else if (pw == sbrd_pkg::PORT_16) begin
            r = (sz == sbrd_pkg::SIZE_BYTE || sz == sbrd_pkg::SIZE_HALF) ?
                sbrd_pkg::LANE_ZERO : sbrd_pkg::LANE_ONE;
        end
        f_lanes = r;
    endfunction

    assign words_next = f_words(miss_size_i);
    assign lanes_next = f_lanes(port_width_i, miss_size_i);

    // ------------------------------------------------------------
    // Request and sequencer
    // ------------------------------------------------------------
    // Read request raised in the stall after a missed run cycle
    assign internal_read_request_o = cache_miss_i && (state_reg == sbrd_pkg::SBRD_IDLE);
    assign stall_o = (state_reg != sbrd_pkg::SBRD_IDLE) ? !ack_reg : cache_miss_i;

    // Capture-enable acts on the edge after it is sampled
    assign word_done = cap_pend_reg && (lane_reg == lanes_reg);
    assign last_word = word_done && (fill_cnt_reg + sbrd_pkg::ONE_WORD == words_reg);
    assign implicit_ack = last_word;
    // Early acknowledge honoured only on quad reads
    assign explicit_ack = !read_acknowledge_n_i && (state_reg == sbrd_pkg::SBRD_DATA) &&
                          ((size_reg == sbrd_pkg::SIZE_QUAD) || last_word);
    // DMA done only counts while data is still being taken
    assign dma_end = dma_reg && dma_transfer_done_i &&
                     (state_reg == sbrd_pkg::SBRD_DATA);

    // Bus state machine
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg <= sbrd_pkg::SBRD_IDLE;
        end else begin
            unique case (state_reg)
                sbrd_pkg::SBRD_IDLE: begin
                    if (internal_read_request_o && !bus_busy_i && !higher_prio_i) begin
                        state_reg <= sbrd_pkg::SBRD_ADDR;
                    end
                end
                sbrd_pkg::SBRD_ADDR: state_reg <= sbrd_pkg::SBRD_DATA;
                sbrd_pkg::SBRD_DATA: begin
                    // Controls stay up until all words are in or a DMA done ends the burst
                    if (last_word || dma_end) begin
                        state_reg <= sbrd_pkg::SBRD_DONE;
                    end
                end
                sbrd_pkg::SBRD_DONE: begin
                    if (unloading == 1'b0 && rb_empty) begin
                        state_reg <= sbrd_pkg::SBRD_IDLE;
                    end
                end
            endcase
        end
    end

    // Latch transaction attributes at read start
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            size_reg <= sbrd_pkg::SIZE_BYTE;
            pw_reg <= sbrd_pkg::PORT_32;
            words_reg <= sbrd_pkg::ONE_WORD;
            lanes_reg <= sbrd_pkg::LANE_ZERO;
            dcache_reg <= 1'b0;
            cacheable_reg <= 1'b0;
            dma_reg <= 1'b0;
            system_address_bus_o <= 32'h0000_0000;
        end else if (state_reg == sbrd_pkg::SBRD_IDLE && internal_read_request_o) begin
            size_reg <= miss_size_i;
            pw_reg <= port_width_i;
            words_reg <= words_next;
            lanes_reg <= lanes_next;
            dcache_reg <= miss_dcache_i;
            cacheable_reg <= miss_cacheable_i;
            dma_reg <= dma_burst_i;
            system_address_bus_o <= miss_addr_i;
        end
    end

    // ------------------------------------------------------------
    // Bus control outputs
    // ------------------------------------------------------------
    // Strobe, latch enable and frame marker registered on the edge
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            bus_read_strobe_o <= 1'b0;
            address_latch_enable_o <= 1'b0;
            burst_frame_marker_o <= 1'b0;
            mem_read_enable_n_o <= 1'b1;
        end else begin
            address_latch_enable_o <= (state_reg == sbrd_pkg::SBRD_IDLE) &&
                internal_read_request_o && !bus_busy_i && !higher_prio_i;
            if (state_reg == sbrd_pkg::SBRD_IDLE) begin
                bus_read_strobe_o <= internal_read_request_o && !bus_busy_i && !higher_prio_i;
                burst_frame_marker_o <= internal_read_request_o && !bus_busy_i &&
                    !higher_prio_i;
                mem_read_enable_n_o <= 1'b1;
            end else if (state_reg == sbrd_pkg::SBRD_ADDR) begin
                mem_read_enable_n_o <= 1'b0;
                burst_frame_marker_o <= (words_reg != sbrd_pkg::ONE_WORD) ||
                    (lanes_reg != sbrd_pkg::LANE_ZERO) || dma_reg;
            end else if (state_reg == sbrd_pkg::SBRD_DATA) begin
                // Marker drops as the final datum is being sampled
                if (!read_capture_enable_n_i && !dma_reg) begin
                    burst_frame_marker_o <= !((fill_cnt_reg + sbrd_pkg::ONE_WORD == words_reg) &&
                        (lane_reg == lanes_reg) && !cap_pend_reg);
                end
                if (last_word || (dma_reg && dma_transfer_done_i)) begin
                    bus_read_strobe_o <= 1'b0;
                    mem_read_enable_n_o <= 1'b1;
                    burst_frame_marker_o <= 1'b0;
                end
            end else begin
                bus_read_strobe_o <= 1'b0;
                mem_read_enable_n_o <= 1'b1;
                burst_frame_marker_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Capture and gathering
    // ------------------------------------------------------------
    // Capture enable sampled only in the data state, after the latch cycle
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cap_pend_reg <= 1'b0;
        end else begin
            cap_pend_reg <= (state_reg == sbrd_pkg::SBRD_DATA) && !read_capture_enable_n_i &&
                !last_word;
        end
    end

    // Lane gathering into a full word
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_reg == sbrd_pkg::SBRD_ADDR) begin
            lane_reg <= sbrd_pkg::LANE_ZERO;
            gather_reg <= 32'h0000_0000;
        end else if (cap_pend_reg) begin
            if (pw_reg == sbrd_pkg::PORT_8) begin
                gather_reg[lane_reg*8 +: 8] <= system_data_bus_i[7:0];
            end else if (pw_reg == sbrd_pkg::PORT_16) begin
                gather_reg[lane_reg[0]*16 +: 16] <= system_data_bus_i[15:0];
            end
            lane_reg <= word_done ? sbrd_pkg::LANE_ZERO : lane_reg + 2'h1;
        end
    end

    // Read buffer write side
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_reg == sbrd_pkg::SBRD_ADDR) begin
            wr_ptr_reg <= '0;
            fill_cnt_reg <= '0;
        end else if (word_done) begin
            wr_ptr_reg <= wr_ptr_reg + 2'h1;
            fill_cnt_reg <= fill_cnt_reg + sbrd_pkg::ONE_WORD;
        end
    end

    // Read buffer storage
    always_ff @(posedge sys_clk_i) begin
        if (word_done) begin
            if (pw_reg == sbrd_pkg::PORT_32) begin
                rb_mem[wr_ptr_reg] <= system_data_bus_i;
            end else if (pw_reg == sbrd_pkg::PORT_8) begin
                rb_mem[wr_ptr_reg] <= {system_data_bus_i[7:0], gather_reg[23:0]} >>
                    (8 * (3 - lane_reg));
            end else begin
                rb_mem[wr_ptr_reg] <= lane_reg[0] ? {system_data_bus_i[15:0], gather_reg[15:0]} :
                    {16'h0000, system_data_bus_i[15:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Acknowledge and unloading
    // ------------------------------------------------------------
    // Acknowledge, explicit or implicit, releases the core
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_reg == sbrd_pkg::SBRD_IDLE) begin
            ack_reg <= 1'b0;
        end else if (explicit_ack || implicit_ack || (dma_reg && dma_transfer_done_i)) begin
            ack_reg <= 1'b1;
        end
    end

    assign rb_empty = (rd_ptr_reg == wr_ptr_reg) && (unload_cnt_reg == fill_cnt_reg);
    assign unloading = ack_reg && (unload_cnt_reg != unload_goal_reg);
    // One entry per cycle once words are present
    assign rb_pop = unloading && (unload_cnt_reg != fill_cnt_reg) && ob_in_ready;

    // Unload pointer and goal; data refill takes one or four words
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_reg == sbrd_pkg::SBRD_ADDR) begin
            rd_ptr_reg <= '0;
            unload_cnt_reg <= '0;
            unload_goal_reg <= words_reg;
        end else begin
            if (rb_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 2'h1;
                unload_cnt_reg <= unload_cnt_reg + sbrd_pkg::ONE_WORD;
            end
            // A DMA burst cut short unloads only the words that arrived
            if (dma_end) begin
                unload_goal_reg <= fill_cnt_reg + {2'h0, word_done};
            end
        end
    end

    // Refill and fixup markers: last word unloaded is the fixup
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            core_refill_o <= 1'b0;
            core_fixup_o <= 1'b0;
        end else begin
            core_fixup_o <= rb_pop &&
                (unload_cnt_reg + sbrd_pkg::ONE_WORD == unload_goal_reg);
            core_refill_o <= rb_pop && cacheable_reg &&
                (dcache_reg ? 1'b1 : 1'b1);
        end
    end

    // ------------------------------------------------------------
    // Two-entry output buffer toward the core
    // ------------------------------------------------------------
    assign ob_in_ready = !ob_valid_reg[1];
    assign core_valid_o = ob_valid_reg[0];
    assign core_data_o = ob_data_reg[0];

    // Shift register buffer so a core stall loses no word
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < sbrd_pkg::OB_DEPTH; i++) begin
                ob_valid_reg[i] <= 1'b0;
                ob_data_reg[i] <= 32'h0000_0000;
            end
        end else begin
            if (core_ready_i && ob_valid_reg[0]) begin
                ob_valid_reg[0] <= ob_valid_reg[1] || rb_pop;
                ob_data_reg[0] <= ob_valid_reg[1] ? ob_data_reg[1] : rb_mem[rd_ptr_reg];
                ob_valid_reg[1] <= ob_valid_reg[1] && rb_pop;
                ob_data_reg[1] <= rb_mem[rd_ptr_reg];
            end else if (rb_pop) begin
                if (!ob_valid_reg[0]) begin
                    ob_valid_reg[0] <= 1'b1;
                    ob_data_reg[0] <= rb_mem[rd_ptr_reg];
                end else begin
                    ob_valid_reg[1] <= 1'b1;
                    ob_data_reg[1] <= rb_mem[rd_ptr_reg];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_ale_start;
        @(posedge sys_clk_i) disable iff (srst_i)
        $rose(address_latch_enable_o) |-> bus_read_strobe_o && burst_frame_marker_o &&
            mem_read_enable_n_o;
    endproperty
    a_ale_start: assert property (p_ale_start) else $error("Read start signals wrong");

    property p_ren_high;
        @(posedge sys_clk_i) disable iff (srst_i)
        address_latch_enable_o |-> mem_read_enable_n_o;
    endproperty
    a_ren_high: assert property (p_ren_high) else $error("Read enable low in address");

    property p_ale_pulse;
        @(posedge sys_clk_i) disable iff (srst_i)
        address_latch_enable_o |=> !address_latch_enable_o;
    endproperty
    a_ale_pulse: assert property (p_ale_pulse) else $error("Latch enable too long");

    property p_start;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_reg == sbrd_pkg::SBRD_IDLE && internal_read_request_o && !bus_busy_i &&
            !higher_prio_i) |=> address_latch_enable_o;
    endproperty
    a_start: assert property (p_start) else $error("Read did not start");

    property p_blocked;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_reg == sbrd_pkg::SBRD_IDLE && (bus_busy_i || higher_prio_i)) |=>
            !address_latch_enable_o;
    endproperty
    a_blocked: assert property (p_blocked) else $error("Read started while blocked");

    property p_req;
        @(posedge sys_clk_i) disable iff (srst_i)
        internal_read_request_o |-> stall_o;
    endproperty
    a_req: assert property (p_req) else $error("Request without stall");

    property p_keep;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_reg == sbrd_pkg::SBRD_DATA && ack_reg && !last_word && !dma_reg) |=>
            bus_read_strobe_o;
    endproperty
    a_keep: assert property (p_keep) else $error("Strobe dropped early");

    property p_fill;
        @(posedge sys_clk_i) disable iff (srst_i)
        word_done |=> fill_cnt_reg == $past(fill_cnt_reg) + sbrd_pkg::ONE_WORD;
    endproperty
    a_fill: assert property (p_fill) else $error("Buffer count did not advance");

    property p_clear;
        @(posedge sys_clk_i) disable iff (srst_i)
        address_latch_enable_o |=> fill_cnt_reg == '0 && wr_ptr_reg == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("Counts not cleared");

endmodule

// [sim/sbrd_mem_model.sv]
// Memory model answering bus reads with capture enables, acknowledge and data
`timescale 1ns/10ps
module sbrd_mem_model (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic address_latch_enable_i,
    input wire logic bus_read_strobe_i,
    input wire logic [4:0] beats_i,
    input wire logic quad_i,
    input wire logic dma_i,
    input wire logic [31:0] base_i,
    output logic read_capture_enable_n_o,
    output logic read_acknowledge_n_o,
    output logic dma_transfer_done_o,
    output logic [31:0] system_data_bus_o
);
    // ----------------------------
    // Beat sequencer
    // ----------------------------
    logic [5:0] step_reg;
    logic [4:0] beat;
    logic active;
    logic [31:0] last_reg;
    // Restart on each latch strobe, stop when all beats are done
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            step_reg <= 6'h3f;
        end else if (address_latch_enable_i) begin
            step_reg <= 6'h00;
        end else if (!bus_read_strobe_i) begin
            // Falling strobe resets the controller
            step_reg <= 6'h3f;
        end else if (step_reg != 6'h3f) begin
            step_reg <= step_reg + 6'h01;
        end
    end
    assign beat = 5'((step_reg - 6'h01) >> 1);
    assign active = (step_reg != 6'h00) && (step_reg != 6'h3f) && (beat < beats_i);
    // One capture enable cycle, then one hold cycle with the same data
    assign read_capture_enable_n_o = !(active && step_reg[0]);
    // Early acknowledge only on quad reads, else with the last datum
    assign read_acknowledge_n_o = !(active && step_reg[0] &&
        (beat == (quad_i ? beats_i - 5'h02 : beats_i - 5'h01)));
    // Released bus shows the inverse of the last datum
    assign system_data_bus_o = active ? base_i + 32'h01010101 * beat : ~last_reg;
    // DMA side ends the burst in the hold cycle of its last beat
    assign dma_transfer_done_o = dma_i && (step_reg == {beats_i, 1'b0});
    always_ff @(posedge sys_clk_i) begin
        if (active) begin
            last_reg <= system_data_bus_o;
        end
    end
endmodule

// [sim/sbrd_read_if_bench.sv]
// Self-checking bench for the system bus read interface
`timescale 1ns/10ps
module sbrd_read_if_bench;
    // ----------------------------
    // Signals and instances
    // ----------------------------
    logic sys_clk_i = 1'b0, srst_i = 1'b1, cache_miss_i = 1'b0, core_ready_i = 1'b0;
    logic bus_busy_i = 1'b0, higher_prio_i = 1'b0, quad = 1'b0, cap_n, ack_n;
    logic miss_cacheable_i = 1'b0, miss_dcache_i = 1'b0;
    logic [31:0] miss_addr_i = 32'h0, base = 32'h0, data;
    logic dma_burst_i = 1'b0, dma_done;
    logic [2:0] miss_size_i = 3'h0;
    logic [1:0] port_width_i = 2'h0;
    logic [4:0] beats = 5'h0;
    logic internal_read_request_o, stall_o, bus_read_strobe_o, address_latch_enable_o;
    logic burst_frame_marker_o, mem_read_enable_n_o, core_valid_o, core_refill_o, core_fixup_o;
    logic [31:0] system_address_bus_o, core_data_o;
    int n_mismatch = 0, n_checks = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    sbrd_read_if i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cache_miss_i(cache_miss_i),
        .miss_addr_i(miss_addr_i), .miss_size_i(miss_size_i),
        .miss_cacheable_i(miss_cacheable_i), .miss_dcache_i(miss_dcache_i),
        .port_width_i(port_width_i), .bus_busy_i(bus_busy_i), .higher_prio_i(higher_prio_i),
        .read_capture_enable_n_i(cap_n), .read_acknowledge_n_i(ack_n),
        .dma_burst_i(dma_burst_i), .dma_transfer_done_i(dma_done),
        .system_data_bus_i(data), .core_ready_i(core_ready_i),
        .internal_read_request_o(internal_read_request_o), .stall_o(stall_o),
        .bus_read_strobe_o(bus_read_strobe_o), .system_address_bus_o(system_address_bus_o),
        .address_latch_enable_o(address_latch_enable_o),
        .burst_frame_marker_o(burst_frame_marker_o), .mem_read_enable_n_o(mem_read_enable_n_o),
        .core_valid_o(core_valid_o), .core_data_o(core_data_o),
        .core_refill_o(core_refill_o), .core_fixup_o(core_fixup_o));
    sbrd_mem_model i_mem (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .address_latch_enable_i(address_latch_enable_o), .bus_read_strobe_i(bus_read_strobe_o),
        .beats_i(beats), .quad_i(quad), .dma_i(dma_burst_i), .base_i(base),
        .read_capture_enable_n_o(cap_n), .read_acknowledge_n_o(ack_n),
        .dma_transfer_done_o(dma_done), .system_data_bus_o(data));
    // ----------------------------
    // Shared tasks
    // ----------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [31:0] beat_val(input logic [31:0] s, input int k);
        return s + 32'h01010101 * k;
    endfunction
    // Little-endian gathering of narrow lanes, lane 0 first
    function automatic logic [31:0] exp_word(input logic [31:0] s, input logic [1:0] p, input int w);
        logic [31:0] a, b, c, d;
        a = beat_val(s, 4 * w);
        b = beat_val(s, 4 * w + 1);
        c = beat_val(s, 4 * w + 2);
        d = beat_val(s, 4 * w + 3);
        if (p == sbrd_pkg::PORT_32) return beat_val(s, w);
        if (p == sbrd_pkg::PORT_8) return {d[7:0], c[7:0], b[7:0], a[7:0]};
        a = beat_val(s, 2 * w);
        b = beat_val(s, 2 * w + 1);
        return {b[15:0], a[15:0]};
    endfunction
    // One whole read: request, address phase checks, words to the core, one fixup
    task automatic read_run(input logic [31:0] addr, input logic [2:0] size,
            input logic [1:0] port, input int nw, input int hold);
        int i, w, fix, nref, bpw;
        logic st;
        w = 0;
        fix = 0;
        nref = 0;
        bpw = (port == sbrd_pkg::PORT_32) ? 1 : (port == sbrd_pkg::PORT_16) ? 2 : 4;
        miss_addr_i <= addr;
        miss_size_i <= size;
        port_width_i <= port;
        beats <= 5'(nw * bpw);
        quad <= (size == sbrd_pkg::SIZE_QUAD);
        miss_cacheable_i <= (size == sbrd_pkg::SIZE_QUAD);
        miss_dcache_i <= (size == sbrd_pkg::SIZE_QUAD);
        base <= addr ^ 32'h5a5a0000;
        cache_miss_i <= 1'b1;
        core_ready_i <= (hold == 0);
        for (i = 0; i < 400 && w < nw; i++) begin
            @(negedge sys_clk_i);
            st = stall_o;
            if (address_latch_enable_o === 1'b1) begin
                check(system_address_bus_o, addr);
                check({31'h0, mem_read_enable_n_o}, 32'h1);
                check({30'h0, burst_frame_marker_o, bus_read_strobe_o}, 32'h3);
            end
            if (core_fixup_o === 1'b1) fix++;
            if (core_refill_o === 1'b1) nref++;
            if (core_valid_o === 1'b1 && core_ready_i === 1'b1) begin
                check(core_data_o, exp_word(base, port, w));
                w++;
            end
            @(posedge sys_clk_i);
            if (st === 1'b0) cache_miss_i <= 1'b0;
            if (i == hold) core_ready_i <= 1'b1;
        end
        cache_miss_i <= 1'b0;
        if (w < nw) begin
            n_mismatch++;
            stop_test();
        end
        repeat (4) begin
            @(negedge sys_clk_i);
            if (core_fixup_o === 1'b1) fix++;
            if (core_refill_o === 1'b1) nref++;
        end
        check(32'(fix), 32'h1);
        check(32'(nref), (size == sbrd_pkg::SIZE_QUAD) ? 32'(nw) : 32'h0);
        check({31'h0, bus_read_strobe_o}, 32'h0);
        @(posedge sys_clk_i);
    endtask
    // ----------------------------
    // Scenarios
    // ----------------------------
    task automatic t_single32();
        read_run(32'h00001000, sbrd_pkg::SIZE_WORD, sbrd_pkg::PORT_32, 1, 0);
    endtask
    task automatic t_quad_stall();
        read_run(32'h00002000, sbrd_pkg::SIZE_QUAD, sbrd_pkg::PORT_32, 4, 14);
    endtask
    task automatic t_byte_gather();
        read_run(32'h00003004, sbrd_pkg::SIZE_WORD, sbrd_pkg::PORT_8, 1, 0);
    endtask
    task automatic t_half_quad();
        read_run(32'h00004000, sbrd_pkg::SIZE_QUAD, sbrd_pkg::PORT_16, 4, 0);
    endtask
    // DMA burst of a block ended by done after two words
    task automatic t_dma();
        dma_burst_i <= 1'b1;
        read_run(32'h00006000, sbrd_pkg::SIZE_QUAD, sbrd_pkg::PORT_32, 2, 0);
        dma_burst_i <= 1'b0;
    endtask
    // A busy bus and a higher-priority claim hold the start back
    task automatic t_busy();
        int n;
        n = 0;
        bus_busy_i <= 1'b1;
        higher_prio_i <= 1'b1;
        miss_addr_i <= 32'h00005000;
        cache_miss_i <= 1'b1;
        repeat (8) begin
            @(negedge sys_clk_i);
            if (address_latch_enable_o !== 1'b0) n++;
        end
        check(32'(n), 32'h0);
        @(posedge sys_clk_i);
        bus_busy_i <= 1'b0;
        higher_prio_i <= 1'b0;
        read_run(32'h00005000, sbrd_pkg::SIZE_WORD, sbrd_pkg::PORT_32, 1, 0);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        t_single32();
        t_quad_stall();
        t_byte_gather();
        t_half_quad();
        t_dma();
        t_busy();
        stop_test();
    end
endmodule
